// ==== fidgp_dev_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Flash device seen from its pins
// ****************************************
module fidgp_dev_model #(
	parameter logic [7:0] MAKER_CODE = 8'hA5, // Arbitrary value
	parameter logic [7:0] DEV1_CODE  = 8'h3C, // Arbitrary value
	parameter logic [7:0] DEV2_CODE  = 8'h5A, // Arbitrary value
	parameter logic [7:0] DEV3_CODE  = 8'h69, // Arbitrary value
	parameter logic [7:0] SEC_CODE   = 8'h08  // Secured indicator
) (
	input  wire logic [fidgp_pkg::ADDR_W-1:0] addr,      // Address pins
	input  wire logic                         ce_n,      // Chip enable
	input  wire logic                         oe_n,      // Output enable
	input  wire logic                         we_n,      // Write enable
	input  wire logic                         hv_a9,     // Elevated on A9
	input  wire logic                         hv_rst,    // Elevated on reset
	input  wire logic                         dq_oe,     // Host drives data
	input  wire logic                         fail_prot, // Ignore protects
	output logic [fidgp_pkg::DATA_W-1:0]      dq,        // Data to host
	output logic                              seq_err    // Misuse seen
);
	import fidgp_pkg::*;
	logic [NUM_GROUPS-1:0] prot_q;
	logic [7:0]            code;
	int                    grp;
	int                    wr_grp;
	logic                  wr_a6, wr_live;
	wire logic [5:0]       sect   = addr[GRP_LSB +: GROUP_W];
	wire logic             rd_en  = !ce_n && !oe_n && we_n;
	wire logic             sel_ok = hv_rst || (hv_a9 && !addr[A6_BIT]);
	always_comb begin
		if (sect < 6'h04) grp = int'(sect);
		else if (sect < 6'h3C) grp = 4 + (int'(sect) - 4) / 4;
		else grp = int'(sect) - 42;
	end
	always_comb begin
		case (addr[SEL_W-1:0])
			SEL_MAKER:   code = MAKER_CODE;
			SEL_DEV1:    code = DEV1_CODE;
			SEL_DEV2:    code = DEV2_CODE;
			SEL_DEV3:    code = DEV3_CODE;
			SEL_SECURED: code = SEC_CODE;
			SEL_GROUP:   code = {7'h00, prot_q[grp]};
			default:     code = 8'hFF;
		endcase
	end
	// Released bus shows the inverse so a stale byte never matches
	assign dq = (rd_en && sel_ok) ? code : ~code;
	initial begin
		prot_q = '0;
		seq_err = 1'b0;
		wr_live = 1'b0;
	end
	// Address latched on the falling strobe, applied on the rising one
	always @(negedge we_n) begin
		if (!ce_n) begin
			if (hv_a9 || !hv_rst || !dq_oe) seq_err = 1'b1;
			if (addr[A6_BIT] && !(&prot_q)) seq_err = 1'b1;
			wr_grp = grp;
			wr_a6 = addr[A6_BIT];
			wr_live = 1'b1;
		end
	end
	always @(posedge we_n) begin
		if (wr_live && !fail_prot) prot_q[wr_grp] = !wr_a6;
		wr_live = 1'b0;
	end
	always @(negedge oe_n) begin
		if (dq_oe) seq_err = 1'b1;
	end
endmodule // fidgp_dev_model
`default_nettype wire

// ==== fidgp_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module fidgp_host (
	input  wire logic                           clk_sys,   // 125 MHz clock
	input  wire logic                           rstn,      // Sync reset, low
	input  wire logic                           ce,        // Clock enable
	input  wire logic                           req_valid, // Start request
	input  wire fidgp_pkg::fidgp_op_t           req_op,    // Operation
	input  wire logic [fidgp_pkg::SEL_W-1:0]    req_sel,   // Code select
	input  wire logic [fidgp_pkg::GROUP_W-1:0]  req_group, // Group number
	output logic                                req_ready, // Idle
	output logic                                rsp_valid, // Result pulse
	output logic [fidgp_pkg::DATA_W-1:0]        rsp_data,  // Read result
	output logic                                rsp_err,   // Protect failed
	output logic [fidgp_pkg::ADDR_W-1:0]        addr,      // Address pins
	output logic                                ce_n,      // Chip enable
	output logic                                oe_n,      // Output enable
	output logic                                we_n,      // Write enable
	output logic                                hv_a9,     // Elevated on A9
	output logic                                hv_rst,    // Elevated on reset
	input  wire logic [fidgp_pkg::DATA_W-1:0]   dq_i,      // Data pins in
	output logic [fidgp_pkg::DATA_W-1:0]        dq_o,      // Data pins out
	output logic                                dq_oe      // Data drive enable
);
	import fidgp_pkg::*;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// First sector of each group, A20-A15
	function automatic logic [5:0] grp_base(input logic [5:0] g);
		logic [5:0] r;
		r = 6'h00;
		if (g < 6'h04) begin
			r = g;
		end else if (g >= 6'h12) begin
			r = g + 6'h2A;
		end else begin
			// Middle groups of four start at sector 4g-12
			r = {g[3:0] - 4'h3, 2'h0};
		end
		return r;
	endfunction

	function automatic logic [CNT_W-1:0] cyc(input int n);
		return CNT_W'(n);
	endfunction

	typedef enum logic [2:0] {
		FIDGP_IDLE, FIDGP_SETUP, FIDGP_READ, FIDGP_WRITE, FIDGP_REC,
		FIDGP_SCAN, FIDGP_DONE
	} fidgp_state_t;

	fidgp_state_t            st_q;
	fidgp_op_t               op_q;
	logic [CNT_W-1:0]        cnt_q;
	logic [GROUP_W-1:0]      grp_q;
	logic [SEL_W-1:0]        sel_q;
	logic                    scan_q;
	logic [GROUP_W-1:0]      tgt_q;
	logic [DATA_W-1:0]       dq_s;

	fidgp_sync u_sync (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.ce      (ce),
		.d_in    (dq_i),
		.d_out   (dq_s)
	);

	wire logic [5:0] grp_addr = grp_base(grp_q);
	wire logic [ADDR_W-1:0] id_addr = {grp_addr, 15'h0000} |
		ADDR_W'(sel_q);
	wire logic [ADDR_W-1:0] grp_pin = {grp_addr, 15'h0000} |
		ADDR_W'(SEL_GROUP);
	// Only the last unprotect write raises A6; sweep writes protect
	wire logic unpr_wr = (op_q == FIDGP_OP_UNPR) && !scan_q;
	wire logic [ADDR_W-1:0] wr_pin = grp_pin |
		(ADDR_W'(unpr_wr) << A6_BIT);
	wire logic last_grp = (grp_q == GROUP_W'(NUM_GROUPS - 1));
	// Pins show the released level by verify time; judge the latched byte
	wire logic is_prot = (rsp_data == STAT_PROT);

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			st_q <= FIDGP_IDLE;
			op_q <= FIDGP_OP_ID;
			cnt_q <= '0;
			grp_q <= '0;
			sel_q <= '0;
			scan_q <= 1'b0;
			tgt_q <= '0;
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data <= 8'h00;
			rsp_err <= 1'b0;
			addr <= '0;
			ce_n <= 1'b1;
			oe_n <= 1'b1;
			we_n <= 1'b1;
			hv_a9 <= 1'b0;
			hv_rst <= 1'b0;
			dq_o <= 8'h00;
			dq_oe <= 1'b0;
		end else if (ce) begin
			rsp_valid <= 1'b0;
			case (st_q)
			FIDGP_IDLE: begin
				req_ready <= 1'b1;
				if (req_valid && req_ready) begin
					req_ready <= 1'b0;
					op_q <= req_op;
					sel_q <= req_sel;
					grp_q <= req_group;
					tgt_q <= req_group;
					rsp_err <= 1'b0;
					// Unprotect first sweeps every group protected
					scan_q <= (req_op == FIDGP_OP_UNPR);
					if (req_op == FIDGP_OP_UNPR) begin
						grp_q <= '0;
					end
					st_q <= FIDGP_SETUP;
					cnt_q <= '0;
				end
			end
			FIDGP_SETUP: begin
				ce_n <= 1'b0;
				if (op_q == FIDGP_OP_ID) begin
					hv_a9 <= 1'b1;
					addr <= id_addr;
					st_q <= FIDGP_READ;
				end else begin
					// Elevated level only on the reset pin
					hv_rst <= 1'b1;
					addr <= wr_pin;
					dq_o <= 8'h60;
					dq_oe <= 1'b1;
					st_q <= FIDGP_WRITE;
				end
				cnt_q <= '0;
			end
			FIDGP_READ: begin
				oe_n <= 1'b0;
				cnt_q <= cnt_q + 1'b1;
				// Extra two cycles absorb the pin synchroniser
				if (cnt_q == cyc(ACC_CYC + 2)) begin
					oe_n <= 1'b1;
					st_q <= FIDGP_REC;
					rsp_data <= dq_s;
				end
			end
			FIDGP_WRITE: begin
				cnt_q <= cnt_q + 1'b1;
				if (cnt_q < cyc(WP_CYC)) begin
					we_n <= 1'b0;
				end else begin
					we_n <= 1'b1;
				end
				// Data and address held one cycle past the rising strobe
				if (cnt_q == cyc(WP_CYC + 1)) begin
					dq_oe <= 1'b0;
					addr <= grp_pin;
				end
				// Recovery gap before the verify read turns the bus
				if (cnt_q == cyc(WP_CYC + REC_CYC)) begin
					cnt_q <= '0;
					st_q <= FIDGP_READ;
				end
			end
			FIDGP_REC: begin
				cnt_q <= cnt_q + 1'b1;
				if (cnt_q == cyc(ACC_CYC + 2 + REC_CYC)) begin
					st_q <= (op_q == FIDGP_OP_ID) ? FIDGP_DONE : FIDGP_SCAN;
				end
			end
			FIDGP_SCAN: begin
				// Verify: protect expects one, unprotect expects zero
				if (scan_q) begin
					if (!is_prot) rsp_err <= 1'b1;
					if (last_grp) begin
						scan_q <= 1'b0;
						grp_q <= tgt_q;
					end else begin
						grp_q <= grp_q + 1'b1;
					end
					st_q <= FIDGP_SETUP;
				end else begin
					if (is_prot != (op_q == FIDGP_OP_PROT)) rsp_err <= 1'b1;
					st_q <= FIDGP_DONE;
				end
			end
			default: begin
				ce_n <= 1'b1;
				oe_n <= 1'b1;
				hv_a9 <= 1'b0;
				hv_rst <= 1'b0;
				rsp_valid <= 1'b1;
				st_q <= FIDGP_IDLE;
			end
			endcase
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	AST_HV_EXCL: assert property (
		@(posedge clk_sys) disable iff (!rstn) !(hv_a9 && hv_rst))
		else $error("both elevated levels at once");
	AST_A9_READ: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		(op_q == FIDGP_OP_ID && !oe_n) |-> hv_a9 && !ce_n && we_n)
		else $error("id read without elevated A9");
	AST_A6_LOW: assert property (
		@(posedge clk_sys) disable iff (!rstn) !oe_n |-> !addr[A6_BIT])
		else $error("A6 high during read");
	// Seven cycles is the write pulse rounded up to whole clocks
	AST_WE_PULSE: assert property (
		@(posedge clk_sys) disable iff (!rstn) $fell(we_n) |-> !we_n [*7])
		else $error("write pulse short");
	AST_REC_GAP: assert property (
		@(posedge clk_sys) disable iff (!rstn) $rose(we_n) |-> ##1 oe_n)
		else $error("no write recovery");
	AST_UNPR_SWEEP: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		(ce && st_q == FIDGP_IDLE && req_valid && req_ready &&
		req_op == FIDGP_OP_UNPR) |=> scan_q && grp_q == '0)
		else $error("unprotect without sweep");
	AST_UNPR_LAST: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		(!we_n && addr[A6_BIT]) |-> op_q == FIDGP_OP_UNPR && !scan_q)
		else $error("unprotect write before the sweep ends");
	AST_RSP_PULSE: assert property (
		@(posedge clk_sys) disable iff (!rstn) rsp_valid && ce |=> !rsp_valid)
		else $error("response not a pulse");
	AST_DRIVE_WR: assert property (
		@(posedge clk_sys) disable iff (!rstn) !oe_n |-> !dq_oe)
		else $error("bus contention");
	AST_WR_DRIVE: assert property (
		@(posedge clk_sys) disable iff (!rstn) !we_n |-> dq_oe && hv_rst)
		else $error("write without data or elevated reset");
endmodule // fidgp_host
`default_nettype wire

// ==== fidgp_pkg.sv ====
// What this block does
// - Hold elevated select voltage on A9 throughout
// - Low chip/output enables, A6 low, A3-A0 select
// - Group address on high lines, others don't-care
// - Protect/unprotect with elevated voltage on reset only
// - Ordinary bus cycle timing for protect cycles
// - Protect all unprotected groups before unprotecting
package fidgp_pkg;
	localparam int ADDR_W       = 21;
	localparam int DATA_W       = 8;
	localparam int GROUP_W      = 6;
	localparam int NUM_GROUPS   = 22;
	localparam int GRP_LSB      = 15;
	localparam int A9_BIT       = 9;
	localparam int A6_BIT       = 6;
	localparam int SEL_W        = 4;
	localparam logic [3:0] SEL_MAKER   = 4'h0;
	localparam logic [3:0] SEL_DEV1    = 4'h1;
	localparam logic [3:0] SEL_GROUP   = 4'h2;
	localparam logic [3:0] SEL_SECURED = 4'h3;
	localparam logic [3:0] SEL_DEV2    = 4'h6;
	localparam logic [3:0] SEL_DEV3    = 4'h7;
	// Bus phase lengths: 90 ns access, 50 ns write pulse, 30 ns recovery
	localparam int CLK_NS       = 8;
	localparam int T_ACC_NS     = 90;
	localparam int T_WP_NS      = 50;
	localparam int T_REC_NS     = 30;
	localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
	localparam int WP_CYC  = (T_WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int REC_CYC = (T_REC_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W        = 5;
	localparam logic [7:0] STAT_PROT   = 8'h01;
	typedef enum logic [1:0] {
		FIDGP_OP_ID    = 2'h0,
		FIDGP_OP_PROT  = 2'h1,
		FIDGP_OP_UNPR  = 2'h2
	} fidgp_op_t;
endpackage

// ==== fidgp_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module fidgp_sync (
	input  wire logic       clk_sys, // System clock
	input  wire logic       rstn,    // Sync reset, active low
	input  wire logic       ce,      // Clock enable
	input  wire logic [7:0] d_in,    // Asynchronous pin data
	output logic      [7:0] d_out    // Synchronised data
);
	logic [7:0] meta_q;
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			meta_q <= 8'h00;
			d_out  <= 8'h00;
		end else if (ce) begin
			meta_q <= d_in;
			d_out  <= meta_q;
		end
	end
endmodule // fidgp_sync
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Scenarios and verdict
// ****************************************
module tb_top;
	import fidgp_pkg::*;
	logic               clk_sys, rstn, req_valid, fail_prot, saw_hv;
	logic               ce_on;
	logic [GROUP_W-1:0] rd_sect;
	int                 tick;
	fidgp_op_t          req_op;
	logic [SEL_W-1:0]   req_sel;
	logic [GROUP_W-1:0] req_group;
	logic               req_ready, rsp_valid, rsp_err, ce_n, oe_n, we_n;
	logic               hv_a9, hv_rst, dq_oe, seq_err;
	logic [DATA_W-1:0]  rsp_data, dq_i, dq_o;
	logic [ADDR_W-1:0]  addr;
	int                 err_total, comparisons;
	fidgp_host uut (.clk_sys(clk_sys), .rstn(rstn), .ce(ce_on),
		.req_valid(req_valid), .req_op(req_op), .req_sel(req_sel),
		.req_group(req_group), .req_ready(req_ready), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .rsp_err(rsp_err), .addr(addr), .ce_n(ce_n),
		.oe_n(oe_n), .we_n(we_n), .hv_a9(hv_a9), .hv_rst(hv_rst),
		.dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe));
	fidgp_dev_model dev (.addr(addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
		.hv_a9(hv_a9), .hv_rst(hv_rst), .dq_oe(dq_oe),
		.fail_prot(fail_prot), .dq(dq_i), .seq_err(seq_err));
	task automatic chk(input string what, input logic [7:0] exp, got);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic run(input fidgp_op_t op, input logic [3:0] sel,
		input logic [5:0] grp);
		int n;
		n = 0;
		while (req_ready !== 1'b1 && n < 100) begin
			@(negedge clk_sys);
			n++;
		end
		req_op = op;
		req_sel = sel;
		req_group = grp;
		req_valid = 1'b1;
		// Held until ready drops, so a frozen edge does not lose it
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (req_ready === 1'b1 && n < 100);
		req_valid = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 5000) begin
			@(negedge clk_sys);
			n++;
		end
		chk("rsp_valid", 8'h01, {7'h00, rsp_valid});
	endtask
	// First sector of a group: four singles, fours, then four singles
	function automatic logic [5:0] sect_of(input logic [5:0] g);
		int s;
		s = (g < 4) ? int'(g) : (g < 18) ? 4 * int'(g) - 12 : int'(g) + 42;
		return 6'(s);
	endfunction
	task automatic stat(input logic [5:0] grp, input logic [7:0] exp);
		run(FIDGP_OP_ID, SEL_GROUP, grp);
		chk("group status", exp, rsp_data);
		chk("sector", {2'h0, sect_of(grp)}, {2'h0, rd_sect});
	endtask
	task automatic t_codes;
		logic [3:0] sel [5] = '{SEL_MAKER, SEL_DEV1, SEL_DEV2, SEL_DEV3,
			SEL_SECURED};
		logic [7:0] exp [5] = '{8'hA5, 8'h3C, 8'h5A, 8'h69, 8'h08};
		saw_hv = 1'b0;
		for (int i = 0; i < 5; i++) begin
			run(FIDGP_OP_ID, sel[i], 6'h00);
			chk("id code", exp[i], rsp_data);
		end
		chk("a9 select", 8'h01, {7'h00, saw_hv});
	endtask
	task automatic t_prot;
		stat(6'h00, 8'h00);
		stat(6'h15, 8'h00);
		run(FIDGP_OP_PROT, SEL_GROUP, 6'h05);
		chk("protect err", 8'h00, {7'h00, rsp_err});
		run(FIDGP_OP_PROT, SEL_GROUP, 6'h15);
		stat(6'h05, 8'h01);
		stat(6'h04, 8'h00);
		stat(6'h06, 8'h00);
		stat(6'h15, 8'h01);
	endtask
	task automatic t_unprot;
		run(FIDGP_OP_UNPR, SEL_GROUP, 6'h05);
		chk("unprotect err", 8'h00, {7'h00, rsp_err});
		stat(6'h05, 8'h00);
		stat(6'h00, 8'h01);
		stat(6'h11, 8'h01);
		chk("bus misuse", 8'h00, {7'h00, seq_err});
	endtask
	// Device ignoring the write must surface as a failed protect
	task automatic t_fail;
		run(FIDGP_OP_UNPR, SEL_GROUP, 6'h03);
		fail_prot = 1'b1;
		run(FIDGP_OP_PROT, SEL_GROUP, 6'h03);
		chk("refused protect", 8'h01, {7'h00, rsp_err});
		fail_prot = 1'b0;
		stat(6'h03, 8'h00);
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	always @(negedge clk_sys) begin
		// A one-cycle clock-enable gap every 37 cycles stretches whichever bus phase it lands in
		tick++;
		ce_on = (tick % 37 != 5);
		if (!oe_n && hv_a9) saw_hv = 1'b1;
		if (!oe_n) rd_sect = addr[GRP_LSB +: GROUP_W];
	end
	initial begin
		rstn = 1'b0;
		ce_on = 1'b1;
		rd_sect = 6'h00;
		req_valid = 1'b0;
		req_op = FIDGP_OP_ID;
		req_sel = 4'h0;
		req_group = 6'h00;
		fail_prot = 1'b0;
		saw_hv = 1'b0;
		err_total = 0;
		comparisons = 0;
		repeat (16) @(negedge clk_sys);
		rstn = 1'b1;
		t_codes();
		t_prot();
		t_unprot();
		t_fail();
		wrap_up();
	end
	initial begin
		repeat (60000) @(posedge clk_sys);
		err_total++;
		wrap_up();
	end
endmodule // tb_top
`default_nettype wire
